/* File: core/fcor_pkg.sv */
// Constants, field layouts and carrier types of the engine output register bank.
// How it works
// - Long counter is one unsigned 16-bit value.
// - Low byte at lower address, resets zero.
// - High byte at next address, resets zero.
// - Both counter bytes are host writable.
// - Mask bit one keeps status bit on read.
// - Mask bit zero clears status bit on read.
// - Mask clearing applies only with latch enable.
// - Three status registers, main and mirror alike.
// - Mask is read/write, resets to zero.
// - Engines one to three give flag registers.
// - Flag reads one when event detected.
// - Axis one, two, three map to sensor axes.
// - Front-end results land in axis one flags.
// - Latch enable selects latched or pulsed, resets zero.
// - Embedded status carries long count timeout flag.
package fcor_pkg;

	// ----------------------------------------------------------------
	// Register addresses, embedded page and main page.
	// ----------------------------------------------------------------
	localparam logic [7:0] FCOR_ADDR_EMB_STATUS   = 8'h12;
	localparam logic [7:0] FCOR_ADDR_ENG_STATUS   = 8'h13;
	localparam logic [7:0] FCOR_ADDR_LC_STATUS    = 8'h15;
	localparam logic [7:0] FCOR_ADDR_PAGE_RW      = 8'h17;
	localparam logic [7:0] FCOR_ADDR_COUNT_LOW    = 8'h48;
	localparam logic [7:0] FCOR_ADDR_COUNT_HIGH   = 8'h49;
	localparam logic [7:0] FCOR_ADDR_ACK_MASK     = 8'h4B;
	localparam logic [7:0] FCOR_ADDR_ENG1_FLAGS   = 8'h4C;
	localparam logic [7:0] FCOR_ADDR_ENG2_FLAGS   = 8'h4D;
	localparam logic [7:0] FCOR_ADDR_ENG3_FLAGS   = 8'h4E;
	localparam logic [7:0] FCOR_ADDR_EMB_MIRROR   = 8'h49;
	localparam logic [7:0] FCOR_ADDR_ENG_MIRROR   = 8'h4A;
	localparam logic [7:0] FCOR_ADDR_LC_MIRROR    = 8'h4B;

	// ----------------------------------------------------------------
	// Field positions and reset values.
	// ----------------------------------------------------------------
	localparam int          FCOR_LATCH_BIT        = 7;
	localparam int          FCOR_TIMEOUT_BIT      = 7;
	localparam int          FCOR_ENGINES          = 3;
	localparam logic [7:0]  FCOR_BYTE_RESET       = 8'h00;
	localparam logic [15:0] FCOR_COUNT_RESET      = 16'h0000;
	localparam logic [15:0] FCOR_COUNT_ONE        = 16'h0001;
	localparam logic [15:0] FCOR_COUNT_LIMIT      = 16'hFFFF;
	localparam logic [7:0]  FCOR_EMB_VALID        = 8'hB8;
	localparam logic [7:0]  FCOR_LC_VALID         = 8'h0F;
	localparam logic [7:0]  FCOR_PAGE_RW_VALID    = 8'hE0;

	// Status register selector.
	typedef enum logic [1:0] {
		FCOR_SEL_EMB,
		FCOR_SEL_ENG,
		FCOR_SEL_LC
	} fcor_sel_e;

	// Register access request from the serial interface.
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic       main_page;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fcor_req_s;

	// Eight event flags of one engine, bit 7 first.
	typedef struct packed {
		logic axis1_pos;
		logic axis1_neg;
		logic axis2_pos;
		logic axis2_neg;
		logic axis3_pos;
		logic axis3_neg;
		logic vector_pos;
		logic vector_neg;
	} fcor_flags_s;

endpackage

/* File: core/fcor_status_reg.sv */
// One latched status register with mask-governed clear on read.
`timescale 1ns/1ps
module fcor_status_reg (
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] valid_bits,
	input  wire logic       latch_en,
	input  wire logic [7:0] ack_keep_bit,
	input  wire logic [7:0] event_in,
	input  wire logic       read_hit,
	output logic [7:0]      status
);
	import fcor_pkg::*;

	// Live view when unlatched; in latched mode a read clears unkept bits,
	// but a new event in the same cycle wins over the clear.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			status <= FCOR_BYTE_RESET;
		end else if (!latch_en) begin
			status <= event_in & valid_bits;
		end else if (read_hit) begin
			status <= ((status & ack_keep_bit) | event_in) & valid_bits;
		end else begin
			status <= (status | event_in) & valid_bits;
		end
	end

endmodule

/* File: core/fcor_flag_reg.sv */
// Event flag register of one programmable state engine.
`timescale 1ns/1ps
module fcor_flag_reg (
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	input  wire fcor_pkg::fcor_flags_s axis_events,
	input  wire logic                  front_end_pos,
	input  wire logic                  front_end_neg,
	output fcor_pkg::fcor_flags_s      flags
);
	import fcor_pkg::*;

	// Flags mirror the engine's detected state; front-end results are
	// folded into axis one because no separate field exists for them.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			flags <= fcor_flags_s'(FCOR_BYTE_RESET);
		end else begin
			flags <= axis_events;
			flags.axis1_pos <= axis_events.axis1_pos | front_end_pos;
			flags.axis1_neg <= axis_events.axis1_neg | front_end_neg;
		end
	end

endmodule

/* File: core/fcor_regs.sv */
// Long counter, acknowledge mask, status and engine flag register bank.
`timescale 1ns/1ps
module fcor_regs (
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	input  wire fcor_pkg::fcor_req_s   req,
	input  wire logic                  count_tick,
	input  wire logic [7:0]            embedded_events,
	input  wire logic [7:0]            engine_events,
	input  wire logic [7:0]            learning_core_events,
	input  wire fcor_pkg::fcor_flags_s eng1_events,
	input  wire fcor_pkg::fcor_flags_s eng2_events,
	input  wire fcor_pkg::fcor_flags_s eng3_events,
	input  wire logic                  front_end_pos,
	input  wire logic                  front_end_neg,
	output logic [7:0]                 rdata,
	output logic                       rvalid,
	output logic                       embedded_irq_latch_enable,
	output logic [15:0]                long_count_value
);
	import fcor_pkg::*;

	// ----------------------------------------------------------------
	// Address decode.
	// ----------------------------------------------------------------

	logic [7:0]  ack_keep_bit;
	logic [7:0]  embedded_event_status;
	logic [7:0]  engine_event_status;
	logic [7:0]  learning_core_status;
	logic [7:0]  next_rdata;
	logic [7:0]  emb_events_all;
	logic        timeout_pulse;
	logic        rd_emb;
	logic        rd_eng;
	logic        rd_lc;
	fcor_flags_s flags1;
	fcor_flags_s flags2;
	fcor_flags_s flags3;

	// Matches a status read at its embedded or main-page mirror address.
	function automatic logic status_hit(input fcor_req_s r,
		input logic [7:0] emb_addr, input logic [7:0] main_addr);
		status_hit = r.rd && (r.main_page ? (r.addr == main_addr)
			: (r.addr == emb_addr));
	endfunction

	// Both page addresses act on the same flip-flops.
	assign rd_emb = status_hit(req, FCOR_ADDR_EMB_STATUS,
		FCOR_ADDR_EMB_MIRROR);
	assign rd_eng = status_hit(req, FCOR_ADDR_ENG_STATUS,
		FCOR_ADDR_ENG_MIRROR);
	assign rd_lc  = status_hit(req, FCOR_ADDR_LC_STATUS,
		FCOR_ADDR_LC_MIRROR);

	// Embedded-page write strobe for one address.
	function automatic logic emb_wr(input fcor_req_s r, input logic [7:0] a);
		emb_wr = r.wr && !r.main_page && (r.addr == a);
	endfunction

	// ----------------------------------------------------------------
	// Long counter.
	// ----------------------------------------------------------------

	// A host write to either byte presets that byte; a write beats a tick
	// in the same cycle so software always sees the value it wrote.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			long_count_value <= FCOR_COUNT_RESET;
		end else if (emb_wr(req, FCOR_ADDR_COUNT_LOW)) begin
			long_count_value[7:0] <= req.wdata;
		end else if (emb_wr(req, FCOR_ADDR_COUNT_HIGH)) begin
			long_count_value[15:8] <= req.wdata;
		end else if (count_tick) begin
			long_count_value <= long_count_value + FCOR_COUNT_ONE;
		end
	end

	// Timeout fires when the tick carries the count through its limit.
	assign timeout_pulse = count_tick
		&& (long_count_value == FCOR_COUNT_LIMIT)
		&& !emb_wr(req, FCOR_ADDR_COUNT_LOW)
		&& !emb_wr(req, FCOR_ADDR_COUNT_HIGH);

	always_comb begin
		emb_events_all = embedded_events;
		emb_events_all[FCOR_TIMEOUT_BIT] = timeout_pulse;
	end

	// ----------------------------------------------------------------
	// Mask and latch mode.
	// ----------------------------------------------------------------

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ack_keep_bit <= FCOR_BYTE_RESET;
		end else if (emb_wr(req, FCOR_ADDR_ACK_MASK)) begin
			ack_keep_bit <= req.wdata;
		end
	end

	// The page control register lives on the main page.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			embedded_irq_latch_enable <= 1'b0;
		end else if (req.wr && req.main_page
			&& req.addr == FCOR_ADDR_PAGE_RW) begin
			embedded_irq_latch_enable <= req.wdata[FCOR_LATCH_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Status and flag registers.
	// ----------------------------------------------------------------

	fcor_status_reg u_emb (
		.ref_clk      (ref_clk),
		.sys_rst      (sys_rst),
		.valid_bits   (FCOR_EMB_VALID),
		.latch_en     (embedded_irq_latch_enable),
		.ack_keep_bit (ack_keep_bit),
		.event_in     (emb_events_all),
		.read_hit     (rd_emb),
		.status       (embedded_event_status)
	);

	fcor_status_reg u_eng (
		.ref_clk      (ref_clk),
		.sys_rst      (sys_rst),
		.valid_bits   (8'hFF),
		.latch_en     (embedded_irq_latch_enable),
		.ack_keep_bit (ack_keep_bit),
		.event_in     (engine_events),
		.read_hit     (rd_eng),
		.status       (engine_event_status)
	);

	fcor_status_reg u_lc (
		.ref_clk      (ref_clk),
		.sys_rst      (sys_rst),
		.valid_bits   (FCOR_LC_VALID),
		.latch_en     (embedded_irq_latch_enable),
		.ack_keep_bit (ack_keep_bit),
		.event_in     (learning_core_events),
		.read_hit     (rd_lc),
		.status       (learning_core_status)
	);

	fcor_flag_reg u_f1 (
		.ref_clk       (ref_clk),
		.sys_rst       (sys_rst),
		.axis_events   (eng1_events),
		.front_end_pos (front_end_pos),
		.front_end_neg (front_end_neg),
		.flags         (flags1)
	);

	fcor_flag_reg u_f2 (
		.ref_clk       (ref_clk),
		.sys_rst       (sys_rst),
		.axis_events   (eng2_events),
		.front_end_pos (front_end_pos),
		.front_end_neg (front_end_neg),
		.flags         (flags2)
	);

	fcor_flag_reg u_f3 (
		.ref_clk       (ref_clk),
		.sys_rst       (sys_rst),
		.axis_events   (eng3_events),
		.front_end_pos (front_end_pos),
		.front_end_neg (front_end_neg),
		.flags         (flags3)
	);

	// ----------------------------------------------------------------
	// Read mux.
	// ----------------------------------------------------------------

	// Status reads return the value before any clear, so the host sees
	// the flag it is acknowledging. Unmapped addresses read zero.
	always_comb begin
		next_rdata = FCOR_BYTE_RESET;
		if (rd_emb) begin
			next_rdata = embedded_event_status;
		end else if (rd_eng) begin
			next_rdata = engine_event_status;
		end else if (rd_lc) begin
			next_rdata = learning_core_status;
		end else if (req.main_page) begin
			if (req.addr == FCOR_ADDR_PAGE_RW) begin
				next_rdata = {embedded_irq_latch_enable, 7'h00};
			end
		end else begin
			case (req.addr)
				FCOR_ADDR_COUNT_LOW: begin
					next_rdata = long_count_value[7:0];
				end
				FCOR_ADDR_COUNT_HIGH: begin
					next_rdata = long_count_value[15:8];
				end
				FCOR_ADDR_ACK_MASK: begin
					next_rdata = ack_keep_bit;
				end
				FCOR_ADDR_ENG1_FLAGS: begin
					next_rdata = flags1;
				end
				FCOR_ADDR_ENG2_FLAGS: begin
					next_rdata = flags2;
				end
				FCOR_ADDR_ENG3_FLAGS: begin
					next_rdata = flags3;
				end
				default: begin
					next_rdata = FCOR_BYTE_RESET;
				end
			endcase
		end
	end

	// Read data is registered and valid one cycle after the request.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdata  <= FCOR_BYTE_RESET;
			rvalid <= 1'b0;
		end else begin
			rdata  <= next_rdata;
			rvalid <= req.rd;
		end
	end

endmodule

/* File: verif/fcor_regs_checker.sv */
// Port-level assertions for the counter, status and flag register bank.
`timescale 1ns/1ps
module fcor_regs_checker (
	input wire logic                  ref_clk,
	input wire logic                  sys_rst,
	input wire fcor_pkg::fcor_req_s   req,
	input wire logic                  count_tick,
	input wire fcor_pkg::fcor_flags_s eng1_events,
	input wire logic                  front_end_pos,
	input wire logic                  front_end_neg,
	input wire logic [7:0]            rdata,
	input wire logic                  rvalid,
	input wire logic                  embedded_irq_latch_enable,
	input wire logic [15:0]           long_count_value
);
	import fcor_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// ------------------------------------------------------------
	// Write decodes, shared so each property stays short.
	// ------------------------------------------------------------
	logic lo_wr;
	logic hi_wr;
	logic pg_wr;
	assign lo_wr = req.wr && !req.main_page && req.addr == FCOR_ADDR_COUNT_LOW;
	assign hi_wr = req.wr && !req.main_page && req.addr == FCOR_ADDR_COUNT_HIGH;
	assign pg_wr = req.wr && req.main_page && req.addr == FCOR_ADDR_PAGE_RW;
	property p_rd_answer; req.rd |=> rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered");
	property p_count_step;
		count_tick && !lo_wr && !hi_wr |=>
			long_count_value == $past(long_count_value) + 16'h0001;
	endproperty
	a_count_step: assert property (p_count_step)
		else $error("counter did not step");
	property p_low_wr; lo_wr |=> long_count_value[7:0] == $past(req.wdata);
	endproperty
	a_low_wr: assert property (p_low_wr)
		else $error("low byte write lost");
	property p_high_wr; hi_wr |=> long_count_value[15:8] == $past(req.wdata);
	endproperty
	a_high_wr: assert property (p_high_wr)
		else $error("high byte write lost");
	property p_latch_wr;
		pg_wr |=> embedded_irq_latch_enable == $past(req.wdata[7]);
	endproperty
	a_latch_wr: assert property (p_latch_wr)
		else $error("latch enable write lost");
	property p_latch_hold; !pg_wr |=> $stable(embedded_irq_latch_enable);
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("latch enable changed without write");
	property p_reset_vals;
		$fell(sys_rst) |-> long_count_value == 16'h0000 &&
			!embedded_irq_latch_enable && !rvalid;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("bad value after reset");
	// Both front-end results fold into axis one, positive and negative.
	property p_flag_read;
		req.rd && !req.main_page && req.addr == FCOR_ADDR_ENG1_FLAGS &&
		$stable(eng1_events) && $stable(front_end_pos) &&
		$stable(front_end_neg) && !$past(sys_rst) |=> rdata ==
			($past(eng1_events) | {$past(front_end_pos),
			$past(front_end_neg), 6'h00});
	endproperty
	a_flag_read: assert property (p_flag_read)
		else $error("engine one flags misread");
	property p_unmapped; req.rd && req.addr == 8'h40 |=> rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
endmodule
bind fcor_regs fcor_regs_checker fcor_regs_checker_i (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .req(req), .count_tick(count_tick),
	.eng1_events(eng1_events), .front_end_pos(front_end_pos),
	.front_end_neg(front_end_neg), .rdata(rdata), .rvalid(rvalid),
	.embedded_irq_latch_enable(embedded_irq_latch_enable),
	.long_count_value(long_count_value));

/* File: verif/fcor_host_model.sv */
// Host model that issues register reads and writes to the bank.
`timescale 1ns/1ps
module fcor_host_model (
	input  wire logic          ref_clk,
	input  wire logic [7:0]    rdata,
	input  wire logic          rvalid,
	output fcor_pkg::fcor_req_s req
);
	import fcor_pkg::*;
	initial req = '0;
	// A write is a one-cycle strobe taken at the following edge.
	task automatic wr(input logic pg, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		req <= '{rd: 1'b0, wr: 1'b1, main_page: pg, addr: a, wdata: d};
		@(posedge ref_clk);
		req.wr <= 1'b0;
	endtask
	// The answer strobe is awaited a bounded time so a dead bank cannot hang.
	task automatic rd(input logic pg, input logic [7:0] a,
		output logic [7:0] d, output logic ok);
		@(posedge ref_clk);
		req <= '{rd: 1'b1, wr: 1'b0, main_page: pg, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		req.rd <= 1'b0;
		ok = 1'b0;
		d = 8'h00;
		for (int i = 0; i < 4 && !ok; i++) begin
			@(negedge ref_clk);
			ok = (rvalid === 1'b1);
			d = rdata;
		end
	endtask
endmodule

/* File: verif/fcor_regs_test.sv */
// Self-checking bench for the counter, status and flag register bank.
`timescale 1ns/1ps
module fcor_regs_test;
	import fcor_pkg::*;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	fcor_req_s   req;
	logic        count_tick = 1'b0;
	logic [7:0]  emb_ev = 8'h00, eng_ev = 8'h00, lc_ev = 8'h00;
	fcor_flags_s ev1 = '0, ev2 = '0, ev3 = '0;
	logic        fe_pos = 1'b0, fe_neg = 1'b0;
	logic [7:0]  rdata;
	logic        rvalid, latch_en;
	logic [15:0] count;
	int          fails = 0, cmp_count = 0;
	always #5 ref_clk = ~ref_clk;
	fcor_regs fcor_regs_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req),
		.count_tick(count_tick), .embedded_events(emb_ev),
		.engine_events(eng_ev), .learning_core_events(lc_ev),
		.eng1_events(ev1), .eng2_events(ev2), .eng3_events(ev3),
		.front_end_pos(fe_pos), .front_end_neg(fe_neg), .rdata(rdata),
		.rvalid(rvalid), .embedded_irq_latch_enable(latch_en),
		.long_count_value(count));
	fcor_host_model fcor_host_model_i (.ref_clk(ref_clk), .rdata(rdata),
		.rvalid(rvalid), .req(req));
	// ------------------------------------------------------------
	// Compare, access and report tasks.
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic w(input logic pg, input logic [7:0] a, input logic [7:0] d);
		fcor_host_model_i.wr(pg, a, d);
	endtask
	task automatic rc(input logic pg, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       ok;
		fcor_host_model_i.rd(pg, a, d, ok);
		if (ok !== 1'b1) begin
			fails++;
			$display("ERROR %0t read timed out", $time);
			print_verdict();
		end else begin
			chk({8'h00, d}, {8'h00, e});
		end
	endtask
	// A hung run still reaches the verdict.
	initial begin
		#200000;
		fails++;
		$display("ERROR %0t run timed out", $time);
		print_verdict();
	end
	// ------------------------------------------------------------
	// Test sequence.
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rc(0, FCOR_ADDR_COUNT_LOW, 8'h00);
		rc(0, FCOR_ADDR_COUNT_HIGH, 8'h00);
		rc(0, FCOR_ADDR_ACK_MASK, 8'h00);
		rc(1, FCOR_ADDR_PAGE_RW, 8'h00);
		$display("test reset done");
		// Latched mode, then wrap the counter to raise the timeout flag.
		w(1, FCOR_ADDR_PAGE_RW, 8'h80);
		rc(1, FCOR_ADDR_PAGE_RW, 8'h80);
		w(0, FCOR_ADDR_COUNT_LOW, 8'hFF);
		w(0, FCOR_ADDR_COUNT_HIGH, 8'hFF);
		@(posedge ref_clk);
		count_tick <= 1'b1;
		@(posedge ref_clk);
		count_tick <= 1'b0;
		@(negedge ref_clk);
		chk(count, 16'h0000);
		rc(0, FCOR_ADDR_EMB_STATUS, 8'h80);
		rc(1, FCOR_ADDR_EMB_MIRROR, 8'h00);
		w(0, FCOR_ADDR_COUNT_LOW, 8'hA5);
		w(0, FCOR_ADDR_COUNT_HIGH, 8'h5A);
		rc(0, FCOR_ADDR_COUNT_LOW, 8'hA5);
		rc(0, FCOR_ADDR_COUNT_HIGH, 8'h5A);
		chk(count, 16'h5AA5);
		$display("test counter done");
		// Mask keeps the upper two bits; a read clears the rest.
		w(0, FCOR_ADDR_ACK_MASK, 8'hC0);
		rc(0, FCOR_ADDR_ACK_MASK, 8'hC0);
		@(posedge ref_clk);
		eng_ev <= 8'hF0;
		lc_ev <= 8'hFF;
		@(posedge ref_clk);
		eng_ev <= 8'h00;
		lc_ev <= 8'h00;
		rc(0, FCOR_ADDR_ENG_STATUS, 8'hF0);
		rc(1, FCOR_ADDR_ENG_MIRROR, 8'hC0);
		rc(1, FCOR_ADDR_LC_MIRROR, 8'h0F);
		rc(0, FCOR_ADDR_LC_STATUS, 8'h00);
		// Pulsed mode: status follows the live inputs and reads keep them.
		w(1, FCOR_ADDR_PAGE_RW, 8'h00);
		@(posedge ref_clk);
		eng_ev <= 8'h0F;
		rc(0, FCOR_ADDR_ENG_STATUS, 8'h0F);
		rc(1, FCOR_ADDR_ENG_MIRROR, 8'h0F);
		// Only the defined embedded bits pass; input bit 7 is not the timeout.
		@(posedge ref_clk);
		emb_ev <= 8'hFF;
		rc(0, FCOR_ADDR_EMB_STATUS, 8'h38);
		$display("test status done");
		// Engine flags, with the front-end results landing on axis one.
		@(posedge ref_clk);
		eng_ev <= 8'h00;
		emb_ev <= 8'h00;
		ev1 <= 8'h01;
		ev2 <= 8'h42;
		ev3 <= '{axis2_neg: 1'b1, default: 1'b0};
		fe_pos <= 1'b1;
		fe_neg <= 1'b1;
		rc(0, FCOR_ADDR_ENG1_FLAGS, 8'hC1);
		rc(0, FCOR_ADDR_ENG2_FLAGS, 8'hC2);
		rc(0, FCOR_ADDR_ENG3_FLAGS, 8'hD0);
		w(0, FCOR_ADDR_ENG1_FLAGS, 8'h00);
		rc(0, FCOR_ADDR_ENG1_FLAGS, 8'hC1);
		rc(0, 8'h40, 8'h00);
		$display("test flags done");
		// A reset in mid-run must return written state to its defaults.
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(negedge ref_clk);
		chk(count, 16'h0000);
		rc(0, FCOR_ADDR_ACK_MASK, 8'h00);
		rc(0, FCOR_ADDR_COUNT_HIGH, 8'h00);
		$display("test second reset done");
		print_verdict();
	end
endmodule
